// >>> inc/ppc_defs.vh
`ifndef PPC_DEFS_VH
`define PPC_DEFS_VH

`define PPC_NPORTS 4
`define PPC_CLK_MHZ 200
// single-pulse assertion time, not printed: plain default in microseconds
`define PPC_T_SINGLE_US 5
// double-pulse rolling window, ms
`define PPC_T_DOUBLE_MS 20
// cycle counts at the core clock, sized to the counter width
`define PPC_SINGLE_CYC 24'h0003E8
`define PPC_DOUBLE_CYC 24'h3D0900
// power-up blanking of the sense input, microseconds
`define PPC_T_BLANK_US 100
`define PPC_BLANK_CYC 24'h004E20
`define PPC_CNT_W 24
`define PPC_CNT_ZERO 24'h000000
`define PPC_CNT_ONE 24'h000001

`endif

// >>> rtl/ppc_oc_detect.v
`timescale 1ns/1ps
`include "ppc_defs.vh"

module ppc_oc_detect #(
    parameter [`PPC_CNT_W-1:0] SINGLE_CYC = `PPC_SINGLE_CYC,
    parameter [`PPC_CNT_W-1:0] DOUBLE_CYC = `PPC_DOUBLE_CYC,
    parameter [`PPC_CNT_W-1:0] BLANK_CYC = `PPC_BLANK_CYC
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_enable,
    input wire i_sense_n,
    output reg o_fault
);
    reg [`PPC_CNT_W-1:0] blank_reg;
    reg [`PPC_CNT_W-1:0] low_reg;
    reg [`PPC_CNT_W-1:0] win_reg;
    reg prev_low_reg;
    reg armed_reg;
    wire active;
    wire low;
    wire group_start;

    assign active = i_enable && (blank_reg == `PPC_CNT_ZERO);
    assign low = active && !i_sense_n;
    assign group_start = low && !prev_low_reg;

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            blank_reg <= `PPC_CNT_ZERO;
            low_reg <= `PPC_CNT_ZERO;
            win_reg <= `PPC_CNT_ZERO;
            prev_low_reg <= 1'b0;
            armed_reg <= 1'b0;
            o_fault <= 1'b0;
        end else begin
            o_fault <= 1'b0;
            prev_low_reg <= low;
            // blank sense while power comes up
            if (!i_enable) begin
                blank_reg <= BLANK_CYC;
            end else if (blank_reg != `PPC_CNT_ZERO) begin
                blank_reg <= blank_reg - `PPC_CNT_ONE;
            end
            if (low) begin
                if (low_reg == SINGLE_CYC - `PPC_CNT_ONE) begin
                    o_fault <= 1'b1;
                end
                if (low_reg != SINGLE_CYC) begin
                    low_reg <= low_reg + `PPC_CNT_ONE;
                end
            end else begin
                low_reg <= `PPC_CNT_ZERO;
            end
            if (!active) begin
                armed_reg <= 1'b0;
                win_reg <= `PPC_CNT_ZERO;
            end else if (group_start) begin
                if (armed_reg) begin
                    o_fault <= 1'b1;
                    armed_reg <= 1'b0;
                end else begin
                    armed_reg <= 1'b1;
                    win_reg <= DOUBLE_CYC;
                end
            end else if (armed_reg) begin
                if (win_reg == `PPC_CNT_ONE) begin
                    armed_reg <= 1'b0;
                end
                win_reg <= win_reg - `PPC_CNT_ONE;
            end
        end
    end
endmodule

// >>> rtl/ppc_port_ctrl.v
`timescale 1ns/1ps
`include "ppc_defs.vh"

// How it works
// - combined mode: one pin per port
// - power off drives pin low, pull-up off
// - power on releases pin, pull-up on
// - enabled port pin sampled every cycle
// - long continuous low flags over-current
// - two low groups in window flag fault
// - power-up transients blanked, not faults
// - poly fuse open reads low, same handling
// - ganged mode uses one common pin
// - per-port charge supply indication on pins
// - hub logic or processor controls power
module ppc_port_ctrl (
    input wire i_clk,
    input wire i_reset,
    input wire i_gang_mode,
    input wire i_cpu_select,
    input wire [`PPC_NPORTS-1:0] i_hub_power_on,
    input wire [`PPC_NPORTS-1:0] i_cpu_power_on,
    input wire [`PPC_NPORTS-1:0] i_hub_fault_ack,
    input wire [`PPC_NPORTS-1:0] i_cpu_fault_ack,
    input wire [`PPC_NPORTS-1:0] i_charge_enable_strap,
    input wire [`PPC_NPORTS-1:0] i_port_power_sense_pins_in,
    output reg [`PPC_NPORTS-1:0] o_port_power_sense_pins_out,
    output reg [`PPC_NPORTS-1:0] o_port_power_sense_pins_oe,
    output reg [`PPC_NPORTS-1:0] o_port_pullup_en,
    output reg [`PPC_NPORTS-1:0] o_charge_supply_present,
    output reg [`PPC_NPORTS-1:0] o_overcurrent
);
    reg [`PPC_NPORTS-1:0] sync1_reg;
    reg [`PPC_NPORTS-1:0] sync2_reg;
    reg [`PPC_NPORTS-1:0] strap_reg;
    reg strap_taken_reg;
    reg [`PPC_NPORTS-1:0] strap_sync1_reg;
    reg [`PPC_NPORTS-1:0] strap_sync2_reg;
    reg [1:0] strap_age_reg;
    reg [`PPC_NPORTS-1:0] power_reg;
    wire [`PPC_NPORTS-1:0] req;
    wire [`PPC_NPORTS-1:0] ack;
    wire [`PPC_NPORTS-1:0] fault;
    wire [`PPC_NPORTS-1:0] sense_n;
    wire [`PPC_NPORTS-1:0] det_en;
    reg [`PPC_NPORTS-1:0] power_next;
    reg [`PPC_NPORTS-1:0] oc_next;
    integer k;

    // source select: hub logic or processor
    assign req = i_cpu_select ? i_cpu_power_on : i_hub_power_on;
    assign ack = i_cpu_select ? i_cpu_fault_ack : i_hub_fault_ack;

    // ganged: port 0 pin is the common pin
    assign sense_n = i_gang_mode ? {`PPC_NPORTS{sync2_reg[0]}} : sync2_reg;
    assign det_en = i_gang_mode ? {{(`PPC_NPORTS-1){1'b0}}, power_reg[0]} : power_reg;

    genvar g;
    generate
        for (g = 0; g < `PPC_NPORTS; g = g + 1) begin : det
            ppc_oc_detect u_det (
                .i_clk(i_clk),
                .i_reset(i_reset),
                .i_enable(det_en[g] && o_port_power_sense_pins_oe[g] == 1'b0),
                .i_sense_n(sense_n[g]),
                .o_fault(fault[g])
            );
        end
    endgenerate

    always @* begin
        power_next = req;
        oc_next = o_overcurrent;
        if (i_gang_mode) begin
            power_next = {`PPC_NPORTS{req[0]}};
        end
        for (k = 0; k < `PPC_NPORTS; k = k + 1) begin
            if (ack[k]) begin
                oc_next[k] = 1'b0;
            end
            if (i_gang_mode ? fault[0] : fault[k]) begin
                oc_next[k] = 1'b1;
            end
            if (oc_next[k]) begin
                power_next[k] = 1'b0;
            end
        end
        // ganged ports share one switch: any flag cuts all
        if (i_gang_mode && (oc_next != {`PPC_NPORTS{1'b0}})) begin
            power_next = {`PPC_NPORTS{1'b0}};
        end
    end

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sync1_reg <= {`PPC_NPORTS{1'b1}};
            sync2_reg <= {`PPC_NPORTS{1'b1}};
            strap_reg <= {`PPC_NPORTS{1'b0}};
            strap_taken_reg <= 1'b0;
            strap_sync1_reg <= {`PPC_NPORTS{1'b0}};
            strap_sync2_reg <= {`PPC_NPORTS{1'b0}};
            strap_age_reg <= 2'h0;
            power_reg <= {`PPC_NPORTS{1'b0}};
            o_overcurrent <= {`PPC_NPORTS{1'b0}};
            o_port_power_sense_pins_out <= {`PPC_NPORTS{1'b0}};
            o_port_power_sense_pins_oe <= {`PPC_NPORTS{1'b1}};
            o_port_pullup_en <= {`PPC_NPORTS{1'b0}};
            o_charge_supply_present <= {`PPC_NPORTS{1'b0}};
        end else begin
            sync1_reg <= i_port_power_sense_pins_in;
            sync2_reg <= sync1_reg;
            // strap is a pin: two flops, then caught once
            strap_sync1_reg <= i_charge_enable_strap;
            strap_sync2_reg <= strap_sync1_reg;
            strap_age_reg <= {strap_age_reg[0], 1'b1};
            if (strap_age_reg[1] && !strap_taken_reg) begin
                strap_reg <= strap_sync2_reg;
                strap_taken_reg <= 1'b1;
            end
            o_charge_supply_present <= strap_reg;
            power_reg <= power_next;
            o_overcurrent <= oc_next;
            o_port_power_sense_pins_out <= {`PPC_NPORTS{1'b0}};
            o_port_power_sense_pins_oe <= ~power_next;
            o_port_pullup_en <= power_next;
        end
    end
endmodule

// >>> sim/ppc_switch_model.sv
`timescale 1ns/1ps
module ppc_switch_model (
    input wire i_gang,
    input wire [3:0] i_oe,
    input wire [3:0] i_out,
    input wire [3:0] i_pu,
    input wire [3:0] i_fault,
    output wire [3:0] o_pin
);
    // pull-up level shows at once: zero power-good delay
    wire [3:0] each = (i_oe & i_out) | (~i_oe & i_pu & ~i_fault);
    // ganged board ties all pins into one wired net
    assign o_pin = i_gang ? {4{&each}} : each;
endmodule

// >>> sim/ppc_checker.sv
`timescale 1ns/1ps
module ppc_checker (
    input wire i_clk,
    input wire i_reset,
    input wire i_gang_mode,
    input wire i_cpu_select,
    input wire [3:0] i_hub_power_on,
    input wire [3:0] i_cpu_power_on,
    input wire [3:0] i_hub_fault_ack,
    input wire [3:0] i_cpu_fault_ack,
    input wire [3:0] o_port_power_sense_pins_out,
    input wire [3:0] o_port_power_sense_pins_oe,
    input wire [3:0] o_port_pullup_en,
    input wire [3:0] o_charge_supply_present,
    input wire [3:0] o_overcurrent
);
    wire [3:0] oe = o_port_power_sense_pins_oe;
    wire [3:0] pu = o_port_pullup_en;
    wire [3:0] oc = o_overcurrent;
    wire [3:0] rq = i_cpu_select ? i_cpu_power_on : i_hub_power_on;
    wire [3:0] ak = i_hub_fault_ack | i_cpu_fault_ack;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    chk_off_drive_low: assert property ((o_port_power_sense_pins_out | oe & pu) == 4'h0)
        else $error("pin high");
    chk_on_release: assert property ((oe | pu) == 4'hF)
        else $error("pin floats");
    chk_flag_power_off: assert property ((oc & $past(oc) & ~oe) == 4'h0)
        else $error("flag with power");
    chk_flag_sticky: assert property (($past(oc) & ~oc & ~$past(ak)) == 4'h0)
        else $error("flag lost");
    chk_follow_request: assert property (!$past(i_reset) && !$past(i_gang_mode)
        |-> ((pu ^ $past(rq)) & ~oc & ~$past(oc)) == 4'h0)
        else $error("power mismatch");
    chk_gang_common: assert property ($past(i_gang_mode) |-> oe == {4{oe[0]}})
        else $error("gang split");
    chk_charge_stable: assert property (!$past(i_reset, 5) |-> $stable(o_charge_supply_present))
        else $error("charge moved");
    chk_blank_start: assert property ($rose(pu[0]) |-> (!oc[0]) [*8])
        else $error("early flag");
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
    reg clk = 0, rst = 1, gang = 0, csel = 0;
    reg [3:0] hub = 0, cpu = 0, hak = 0, cak = 0, strap = 0, flt = 0;
    wire [3:0] pin, out, oe, pu, chg, oc;
    integer failures = 0, checks = 0, seed = 32'h64AD, cyc = 0, i;
    always #2.5 clk = ~clk;
    ppc_port_ctrl dut (.i_clk(clk), .i_reset(rst), .i_gang_mode(gang), .i_cpu_select(csel),
        .i_hub_power_on(hub), .i_cpu_power_on(cpu), .i_hub_fault_ack(hak),
        .i_cpu_fault_ack(cak), .i_charge_enable_strap(strap),
        .i_port_power_sense_pins_in(pin), .o_port_power_sense_pins_out(out),
        .o_port_power_sense_pins_oe(oe), .o_port_pullup_en(pu),
        .o_charge_supply_present(chg), .o_overcurrent(oc));
    ppc_switch_model sw (.i_gang(gang), .i_oe(oe), .i_out(out), .i_pu(pu), .i_fault(flt),
        .o_pin(pin));
    task chk(input [3:0] seen, input [3:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("wrong value at %0t: %h not %h", $time, seen, exp);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task run(input integer n);
        repeat (n) @(negedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    initial begin
        strap = $random(seed);
        run(12);
        rst = 0;
        run(4);
        chk(chg, strap);
        hub = $random(seed);
        run(1);
        chk(pu, hub);
        chk(oe, ~hub);
        hub = 4'hF;
        flt = 4'h1;
        run(8);
        flt = 4'h0;
        run(20000);
        // ports 2 and 3 short low, port 2 again inside the window
        flt = 4'hC;
        run(10);
        flt = 4'h0;
        run(200);
        flt = 4'h4;
        run(10);
        flt = 4'h0;
        run(10);
        chk(oc, 4'h4);
        flt = 4'h2;
        run(990);
        chk(oc, 4'h4);
        run(20);
        chk(oc, 4'h6);
        flt = 4'h0;
        run(50);
        chk(oc, 4'h6);
        chk(oe, 4'h6);
        hak = 4'h2;
        run(1);
        hak = 4'h0;
        run(2);
        chk(oc, 4'h4);
        chk(pu, 4'hB);
        csel = 1;
        cak = 4'h4;
        run(1);
        cak = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            cpu = $random(seed);
            run(2);
            chk(pu, cpu);
        end
        csel = 0;
        hub = 4'h0;
        run(2);
        gang = 1;
        hub = 4'h1;
        run(2);
        chk(pu, 4'hF);
        run(20000);
        flt = 4'h1;
        run(1010);
        chk(oe, 4'hF);
        chk(oc, 4'hF);
        end_of_test;
    end
endmodule
bind ppc_port_ctrl ppc_checker u_chk (.*);
